//--- src/pom_pkg.sv
// Constants shared by the programmable output macrocell array.
// Assumes a single synchronous clock domain.
`default_nettype none
package pom_pkg;
   localparam int NUM_CELLS = 10;
   localparam int NUM_DED_INPUTS = 12;
   localparam int NUM_ARRAY_INPUTS = 22;
   localparam int LOGIC_TERMS = 8;
   localparam int TERMS_PER_CELL = LOGIC_TERMS + 1;
   localparam int OE_TERM_SLOT = LOGIC_TERMS;
   localparam int ARCH_W = 3;
   localparam int POLARITY_SELECT_BIT = 0;
   localparam int REGISTERED_OR_COMB_BIT = 1;
   localparam int ENABLE_SOURCE_BIT = 2;
   // Unprogrammed: external enable, registered, active low
   localparam logic [ARCH_W-1:0] ARCH_UNPROG = 3'h4;
   localparam logic REG_POWERUP = 1'h0;
   localparam logic FUSE_CONNECTED = 1'h1;
   localparam logic SECURE_CLEAR = 1'h0;
endpackage : pom_pkg
`default_nettype wire

//--- src/pom_macrocell_array.sv
// Sum-of-products array with ten configurable output cells, fuse map and readback.
// Assumes all inputs synchronous to clock; the board resolves pin levels from io_oe.
`default_nettype none
module pom_macrocell_array #(
   parameter int NUM_CELLS = pom_pkg::NUM_CELLS,
   parameter int NUM_DED = pom_pkg::NUM_DED_INPUTS,
   parameter int LOGIC_TERMS = pom_pkg::LOGIC_TERMS
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic [NUM_DED-1:0] ded_in,
   input wire logic ext_oe_n,
   input wire logic [NUM_CELLS-1:0] io_in,
   output logic [NUM_CELLS-1:0] io_out,
   output logic [NUM_CELLS-1:0] io_oe,
   input wire logic fuse_we,
   input wire logic [6:0] fuse_addr,
   input wire logic [2*(NUM_DED+2*NUM_CELLS)-1:0] fuse_data,
   input wire logic arch_we,
   input wire logic [3:0] arch_cell,
   input wire logic [pom_pkg::ARCH_W-1:0] arch_data,
   input wire logic secure_set,
   input wire logic [6:0] rd_addr,
   output logic [2*(NUM_DED+2*NUM_CELLS)-1:0] rd_data,
   output logic secured,
   input wire logic preload_en,
   input wire logic [NUM_CELLS-1:0] preload_data
);
   localparam int TPC = LOGIC_TERMS + 1;
   localparam int NUM_TERMS = NUM_CELLS * TPC;
   // Array sees dedicated pins, cell pins and register feedback
   localparam int NUM_X = NUM_DED + 2 * NUM_CELLS;
   localparam int NUM_COL = 2 * NUM_X;

   typedef struct packed {
      logic [NUM_TERMS-1:0][NUM_COL-1:0] fuse;
      logic [NUM_CELLS-1:0][pom_pkg::ARCH_W-1:0] arch;
      logic secure;
      logic [NUM_CELLS-1:0] cell_reg;
      logic [NUM_CELLS-1:0] pin;
      logic [NUM_CELLS-1:0] oe;
      logic [NUM_COL-1:0] rd;
   } pom_state_s;

   pom_state_s st_q;
   pom_state_s st_d;

   // Even column is true form, odd column is complement
   function automatic logic pom_product_term(
      input logic [NUM_COL-1:0] row,
      input logic [NUM_X-1:0] x
   );
      logic acc;
      acc = 1'h1;
      for (int i = 0; i < NUM_X; i++) begin
         acc = acc & (~row[2*i] | x[i]) & (~row[2*i+1] | ~x[i]);
      end
      return acc;
   endfunction : pom_product_term

   function automatic logic pom_apply_polarity(
      input logic [pom_pkg::ARCH_W-1:0] arch,
      input logic v
   );
      return arch[pom_pkg::POLARITY_SELECT_BIT] ? v : ~v;
   endfunction : pom_apply_polarity

   logic [NUM_X-1:0] array_x;
   logic [NUM_CELLS-1:0] sum_term;
   logic [NUM_CELLS-1:0] oe_term;

   assign array_x = {st_q.cell_reg, io_in, ded_in};

   genvar gc;
   generate
      for (gc = 0; gc < NUM_CELLS; gc++) begin : g_cell
         logic [LOGIC_TERMS-1:0] terms;
         genvar gt;
         for (gt = 0; gt < LOGIC_TERMS; gt++) begin : g_term
            assign terms[gt] = pom_product_term(st_q.fuse[gc*TPC+gt], array_x);
         end
         assign sum_term[gc] = |terms;
         assign oe_term[gc] = pom_product_term(st_q.fuse[gc*TPC+pom_pkg::OE_TERM_SLOT],
            array_x);
      end
   endgenerate

   always_comb begin
      logic [NUM_CELLS-1:0] reg_next;
      logic [pom_pkg::ARCH_W-1:0] a;
      logic drive_val;
      reg_next = '0;
      a = '0;
      drive_val = 1'h0;
      st_d = st_q;
      // Programming only breaks connections, as an erasable cell would
      if (fuse_we && (int'(fuse_addr) < NUM_TERMS)) begin
         st_d.fuse[fuse_addr] = st_q.fuse[fuse_addr] & fuse_data;
      end
      if (arch_we && (int'(arch_cell) < NUM_CELLS)) begin
         st_d.arch[arch_cell] = arch_data;
      end
      if (secure_set) begin
         st_d.secure = 1'h1;
      end
      // Readback hides the pattern once secured, including the cycle it is set
      if (st_d.secure || (int'(rd_addr) >= NUM_TERMS)) begin
         st_d.rd = '0;
      end else begin
         st_d.rd = st_q.fuse[rd_addr];
      end
      // Preload wins over the normal capture
      reg_next = preload_en ? preload_data : sum_term;
      st_d.cell_reg = reg_next;
      for (int c = 0; c < NUM_CELLS; c++) begin
         a = st_q.arch[c];
         // Pin flops track the register, so a registered cell shows no extra lag
         drive_val = a[pom_pkg::REGISTERED_OR_COMB_BIT] ? sum_term[c] : reg_next[c];
         st_d.pin[c] = pom_apply_polarity(a, drive_val);
         st_d.oe[c] = a[pom_pkg::ENABLE_SOURCE_BIT] ? ~ext_oe_n : oe_term[c];
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         st_q.fuse <= {NUM_TERMS * NUM_COL{pom_pkg::FUSE_CONNECTED}};
         st_q.arch <= {NUM_CELLS{pom_pkg::ARCH_UNPROG}};
         st_q.secure <= pom_pkg::SECURE_CLEAR;
         st_q.cell_reg <= {NUM_CELLS{pom_pkg::REG_POWERUP}};
         // Active low default: register low shows as a high pin
         st_q.pin <= {NUM_CELLS{~pom_pkg::REG_POWERUP}};
         st_q.oe <= '0;
         st_q.rd <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign io_out = st_q.pin;
   assign io_oe = st_q.oe;
   assign rd_data = st_q.rd;
   assign secured = st_q.secure;
endmodule : pom_macrocell_array
`default_nettype wire

//--- dv/pom_board.sv
// Board model: resolves each cell pin.
// Assumes a board part drives every released pin.
`default_nettype none
module pom_board (
   input wire logic [9:0] io_out,
   input wire logic [9:0] io_oe,
   input wire logic [9:0] brd_val,
   output logic [9:0] io_in
);
   always_comb io_in = io_oe & io_out | ~io_oe & brd_val;
endmodule : pom_board
`default_nettype wire

//--- dv/pom_props.sv
// Port checker for the array.
// Bound to the array; one clock.
`default_nettype none
module pom_props #(parameter int NUM_CELLS = 10, parameter int NUM_DED = 12) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic ext_oe_n,
   input wire logic [NUM_CELLS-1:0] io_out,
   input wire logic [NUM_CELLS-1:0] io_oe,
   input wire logic arch_we,
   input wire logic secure_set,
   input wire logic [6:0] rd_addr,
   input wire logic [2*(NUM_DED+2*NUM_CELLS)-1:0] rd_data,
   input wire logic secured,
   input wire logic preload_en,
   input wire logic [NUM_CELLS-1:0] preload_data
);
   logic dflt_q;
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   // Default arch until first write
   always_ff @(posedge clock) dflt_q <= sys_rst | (dflt_q & ~arch_we);
   rst_pin_a: assert property ($fell(sys_rst) |-> io_oe == '0 && io_out == '1)
      else $error("pins not idle");
   rst_rd_a: assert property ($fell(sys_rst) |-> rd_data == '0 && !secured)
      else $error("read not clear");
   sec_set_a: assert property (secure_set |=> secured) else $error("not secured");
   sec_hold_a: assert property (secured |=> secured) else $error("lock lost");
   sec_blk_a: assert property (secured |-> rd_data == '0) else $error("leak");
   rd_range_a: assert property (rd_addr > 7'h59 |=> rd_data == '0)
      else $error("bad row read");
   pin_oe_a: assert property (dflt_q |=> io_oe == {NUM_CELLS{~$past(ext_oe_n)}})
      else $error("enable wrong");
   preload_a: assert property (dflt_q && preload_en |=> io_out == ~$past(preload_data))
      else $error("preload wrong");
   cover property (preload_en);
   cover property (secure_set ##1 secured);
   cover property (arch_we);
endmodule : pom_props
bind pom_macrocell_array pom_props #(.NUM_CELLS(NUM_CELLS), .NUM_DED(NUM_DED)) u_props (
   .clock, .sys_rst, .ext_oe_n, .io_out, .io_oe, .arch_we, .secure_set, .rd_addr,
   .rd_data, .secured, .preload_en, .preload_data);
`default_nettype wire

//--- dv/pom_macrocell_array_tb_top.sv
// Bench for the array and board model.
// Inputs change on the falling edge.
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fails++; \
   $display("MISMATCH %0t %h %h", $time, a, b); end end
module pom_macrocell_array_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 0, sys_rst = 1, ext_oe_n = 1, fuse_we = 0, arch_we = 0;
   logic secure_set = 0, preload_en = 0, secured;
   logic [11:0] ded_in = '0;
   logic [9:0] io_in, io_out, io_oe, preload_data = '0, brd_val = '0;
   logic [6:0] fuse_addr = '0, rd_addr = '0;
   logic [63:0] fuse_data = '0, rd_data;
   logic [3:0] arch_cell = '0;
   logic [2:0] arch_data = '0;
   int fails = 0, checked = 0;
   logic fb_prev;
   // Arch, x1, x0, ext enable, cell 0 pin, cell 0 enable
   logic [7:0] rows [8] = '{8'h15, 8'h22, 8'h5d, 8'h75, 8'h94, 8'ha3, 8'hc9, 8'hfe};
   always #10 clock = ~clock;
   pom_macrocell_array dut (.*);
   pom_board board (.*);
   task automatic fw(input logic [6:0] a, input logic [63:0] d);
      @(negedge clock);
      fuse_we = 1;
      fuse_addr = a;
      fuse_data = d;
   endtask : fw
   task automatic test_done;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : test_done
   initial begin
      repeat (2) @(negedge clock);
      sys_rst = 0;
      `CHK({io_out, io_oe, rd_data, secured}, {10'h3ff, 10'h0, 64'h0, 1'b0});
      preload_en = 1;
      preload_data = 10'h2a5;
      @(negedge clock);
      `CHK(io_out, ~10'h2a5);
      preload_en = 0;
      fw(0, 64'h1);
      fw(8, 64'h4);
      fw(9, 64'h1000_0000);
      fw(0, '1);
      @(negedge clock);
      fuse_we = 0;
      @(negedge clock);
      `CHK(rd_data, 64'h1);
      rd_addr = 7'h5a;
      // Cell 2 released, board drives it
      for (int v = 0; v < 2; v++) begin
         brd_val = 10'(v) << 2;
         @(negedge clock);
         `CHK({io_out[1], io_oe[2]}, {~v[0], 1'b0});
      end
      // Cell 3 term fed by its own register complement, so it toggles
      fw(27, 64'h0008_0000_0000_0000);
      @(negedge clock);
      fuse_we = 0;
      fb_prev = io_out[3];
      @(negedge clock);
      `CHK(io_out[3], ~fb_prev);
      preload_en = 1;
      preload_data = '1;
      foreach (rows[i]) begin
         @(negedge clock);
         arch_we = 1;
         arch_data = rows[i][7:5];
         {ded_in[1:0], ext_oe_n} = rows[i][4:2];
         @(negedge clock);
         arch_we = 0;
         @(negedge clock);
         `CHK({io_out[0], io_oe[0]}, rows[i][1:0]);
      end
      secure_set = 1;
      @(negedge clock);
      secure_set = 0;
      `CHK({secured, rd_data}, {1'b1, 64'h0});
      test_done();
   end
   // Tests take about 39 cycles
   initial begin
      #4000;
      fails++;
      test_done();
   end
endmodule : pom_macrocell_array_tb_top
`default_nettype wire
